// >>> hw/bsm_pkg.sv
// Purpose: constants and types for the boiler staging coordinator
// Assumes: 125 MHz clock, APB register access, eight follower slots
// Notes: follower slot n answers at link address n+1; slot 0 is the hosting boiler
package bsm_pkg;
  localparam int          NFLW        = 8;
  localparam int          CLK_KHZ     = 125000;
  localparam int          TICK_MS     = 1000;
  localparam int          TICK_CYC    = TICK_MS * CLK_KHZ / 1000 * 1000;
  localparam logic [6:0]  RATE_FULL   = 7'h64;
  localparam logic [3:0]  COORD_ADDR  = 4'h1;
  // register byte offsets
  localparam logic [7:0]  OFS_CTRL    = 8'h00;
  localparam logic [7:0]  OFS_SETP    = 8'h04;
  localparam logic [7:0]  OFS_HYST    = 8'h08;
  localparam logic [7:0]  OFS_BASE    = 8'h0C;
  localparam logic [7:0]  OFS_ADD     = 8'h10;
  localparam logic [7:0]  OFS_DROP    = 8'h14;
  localparam logic [7:0]  OFS_TIMES   = 8'h18;
  localparam logic [7:0]  OFS_ROT     = 8'h1C;
  localparam logic [7:0]  OFS_GROUP   = 8'h20;
  localparam logic [7:0]  OFS_GAIN    = 8'h24;
  localparam logic [7:0]  OFS_STATUS  = 8'h28;
  localparam logic [7:0]  OFS_RATE    = 8'h2C;
  // control field positions
  localparam int          CTRL_EN     = 0;
  localparam int          CTRL_PROP   = 1;
  localparam int          CTRL_REMOTE = 2;
  localparam int          CTRL_BK_LO  = 3;
  // reset values
  localparam logic [4:0]  RST_CTRL    = 5'h00;
  localparam logic [15:0] RST_SETP    = 16'h0320;
  localparam logic [7:0]  RST_HYST    = 8'h32;
  localparam logic [6:0]  RST_BASE    = 7'h46;
  localparam logic [6:0]  RST_ADDTHR  = 7'h5A;
  localparam logic [6:0]  RST_DRPTHR  = 7'h14;
  localparam logic [15:0] RST_ERR     = 16'h0014;
  localparam logic [15:0] RST_DTIME   = 16'h003C;
  localparam logic [15:0] RST_ROT     = 16'h0E10;
  localparam logic [15:0] RST_GROUP   = 16'h5555;
  localparam logic [7:0]  RST_GAIN    = 8'h04;
  // backup sensor choices and priority groups
  localparam logic [1:0]  BK_NONE     = 2'h0;
  localparam logic [1:0]  BK_LEAD     = 2'h1;
  localparam logic [1:0]  BK_AVG      = 2'h2;
  localparam logic [1:0]  GRP_FIRST   = 2'h0;
  localparam logic [1:0]  GRP_EQUAL   = 2'h1;

  typedef enum logic [1:0] {ST_OFF, ST_WATCH, ST_ADD, ST_DROP} bsm_state_t;

  typedef struct packed {
    logic        fire;
    logic [6:0]  rate;
  } bsm_cmd_t;

  typedef struct packed {
    logic        avail;
    logic        runlim;
    logic [6:0]  actual;
    logic [15:0] outlet;
  } bsm_flw_t;
endpackage : bsm_pkg

// >>> hw/bsm_top.sv
// Purpose: staging coordinator for up to eight boilers on a follower link
// Assumes: follower status/command words are exchanged by a link engine on this clock
// Notes: APB slave with one wait state; temperatures are unsigned 16-bit counts
//
// Our own choices: the APB interface to the registers and the register addresses.
`timescale 1ns/1ps
module bsm_top #(
  parameter int TICK_CYCLES = bsm_pkg::TICK_CYC
) (
  input  wire logic                           clock,
  input  wire logic                           rst,
  input  wire logic [7:0]                     paddr,
  input  wire logic                           psel,
  input  wire logic                           penable,
  input  wire logic                           pwrite,
  input  wire logic [31:0]                    pwdata,
  output logic      [31:0]                    prdata,
  output logic                                pready,
  output logic                                pslverr,
  input  wire logic                           stat_pin,
  input  wire logic                           remote_stat,
  input  wire logic [15:0]                    hdr_temp,
  input  wire logic                           hdr_fault,
  input  wire bsm_pkg::bsm_flw_t [bsm_pkg::NFLW-1:0] flw_stat,
  output bsm_pkg::bsm_cmd_t [bsm_pkg::NFLW-1:0]      flw_cmd,
  output logic                                heat_demand,
  output logic      [3:0]                     lead_addr
);
  localparam int NF = bsm_pkg::NFLW;

  function automatic logic [6:0] clamp_rate(input logic signed [27:0] v);
    if (v < 0) begin
      return 7'h00;
    end else if (v > 28'sd100) begin
      return bsm_pkg::RATE_FULL;
    end else begin
      return v[6:0];
    end
  endfunction : clamp_rate

  // firing order: use-first by address, equalize group counted from the lead, then use-last
  function automatic logic [4:0] rank(input logic [2:0] idx, input logic [2:0] lead,
                                      input logic [1:0] grp);
    logic [2:0] rel;
    rel = idx - lead;
    if (grp == bsm_pkg::GRP_EQUAL) begin
      return {2'h1, rel};
    end else if (grp == bsm_pkg::GRP_FIRST) begin
      return {2'h0, idx};
    end else begin
      return {2'h2, idx};
    end
  endfunction : rank

  // configuration
  logic [4:0]  ctrl_q;
  logic [15:0] setp_q;
  logic [7:0]  hon_q;
  logic [7:0]  hoff_q;
  logic [6:0]  base_q;
  logic [6:0]  add_thr_q;
  logic [6:0]  drp_thr_q;
  logic [15:0] add_err_q;
  logic [15:0] drp_err_q;
  logic [15:0] add_time_q;
  logic [15:0] drp_time_q;
  logic [15:0] rot_time_q;
  logic [15:0] group_q;
  logic [7:0]  kp_q;
  // apb
  logic        pready_q;
  logic        pslverr_q;
  logic [31:0] prdata_q;
  logic        wr_en;
  logic        mapped;
  logic [31:0] rd_val;
  // state
  bsm_pkg::bsm_state_t state_q;
  logic        demand_q;
  logic [7:0]  fire_q;
  logic [2:0]  lead_q;
  logic        rot_pend_q;
  logic [3:0]  lead_addr_q;
  logic [15:0] rot_cnt_q;
  logic [15:0] add_cnt_q;
  logic [15:0] drp_cnt_q;
  logic [31:0] pre_q;
  logic        tick_q;
  logic signed [8:0] integ_q;
  logic [6:0]  pid_q;
  logic [15:0] op_q;
  logic        op_ok_q;
  logic        stat_s1_q;
  logic        stat_s2_q;
  logic        stat_s3_q;
  logic        stat_q;
  bsm_pkg::bsm_cmd_t [NF-1:0] cmd_q;
  // combinational
  logic [7:0]  avail;
  logic [7:0]  live;
  logic [3:0]  nfire;
  logic [3:0]  navail;
  logic [2:0]  add_idx;
  logic        have_add;
  logic [2:0]  drp_idx;
  logic        have_drp;
  logic [2:0]  next_lead;
  logic        rl_short;
  logic        rl_excess;
  logic [18:0] out_sum;
  logic [15:0] op_d;
  logic        op_ok_d;
  logic signed [17:0] err;
  logic        call;
  logic        add_crit;
  logic        drp_crit;
  logic        all_fire;
  logic [6:0]  limit;
  logic [6:0]  share;
  logic signed [27:0] pterm;

  // apb slave: one wait state, writes land at the completing edge
  assign wr_en  = psel & penable & pwrite & pready_q;
  assign mapped = (paddr[1:0] == 2'h0) && (paddr <= bsm_pkg::OFS_RATE);

  always_comb begin
    case (paddr)
      bsm_pkg::OFS_CTRL:   rd_val = {27'h0, ctrl_q};
      bsm_pkg::OFS_SETP:   rd_val = {16'h0, setp_q};
      bsm_pkg::OFS_HYST:   rd_val = {16'h0, hoff_q, hon_q};
      bsm_pkg::OFS_BASE:   rd_val = {25'h0, base_q};
      bsm_pkg::OFS_ADD:    rd_val = {add_err_q, 9'h0, add_thr_q};
      bsm_pkg::OFS_DROP:   rd_val = {drp_err_q, 9'h0, drp_thr_q};
      bsm_pkg::OFS_TIMES:  rd_val = {drp_time_q, add_time_q};
      bsm_pkg::OFS_ROT:    rd_val = {16'h0, rot_time_q};
      bsm_pkg::OFS_GROUP:  rd_val = {16'h0, group_q};
      bsm_pkg::OFS_GAIN:   rd_val = {24'h0, kp_q};
      bsm_pkg::OFS_STATUS: rd_val = {op_q, op_ok_q, demand_q, state_q, 1'b0, lead_q, fire_q};
      bsm_pkg::OFS_RATE:   rd_val = {rot_pend_q, stat_q, 7'h0, avail, nfire, 4'h0, pid_q};
      default:             rd_val = 32'h0;
    endcase
  end

  always_ff @(posedge clock) begin
    if (rst) begin
      pready_q  <= 1'b0;
      pslverr_q <= 1'b0;
      prdata_q  <= 32'h0;
    end else begin
      pready_q  <= psel & penable & ~pready_q;
      pslverr_q <= psel & penable & ~pready_q & ~mapped;
      if (psel & penable & ~pready_q & ~pwrite) begin
        prdata_q <= rd_val;
      end
    end
  end

  always_ff @(posedge clock) begin
    if (rst) begin
      ctrl_q     <= bsm_pkg::RST_CTRL;
      setp_q     <= bsm_pkg::RST_SETP;
      hon_q      <= bsm_pkg::RST_HYST;
      hoff_q     <= bsm_pkg::RST_HYST;
      base_q     <= bsm_pkg::RST_BASE;
      add_thr_q  <= bsm_pkg::RST_ADDTHR;
      drp_thr_q  <= bsm_pkg::RST_DRPTHR;
      add_err_q  <= bsm_pkg::RST_ERR;
      drp_err_q  <= bsm_pkg::RST_ERR;
      add_time_q <= bsm_pkg::RST_DTIME;
      drp_time_q <= bsm_pkg::RST_DTIME;
      rot_time_q <= bsm_pkg::RST_ROT;
      group_q    <= bsm_pkg::RST_GROUP;
      kp_q       <= bsm_pkg::RST_GAIN;
    end else if (wr_en) begin
      // overlapping add/drop settings are accepted as written
      case (paddr)
        bsm_pkg::OFS_CTRL:  ctrl_q <= pwdata[4:0];
        bsm_pkg::OFS_SETP:  setp_q <= pwdata[15:0];
        bsm_pkg::OFS_HYST:  begin
          hon_q  <= pwdata[7:0];
          hoff_q <= pwdata[15:8];
        end
        bsm_pkg::OFS_BASE:  base_q <= pwdata[6:0];
        bsm_pkg::OFS_ADD:   begin
          add_thr_q <= pwdata[6:0];
          add_err_q <= pwdata[31:16];
        end
        bsm_pkg::OFS_DROP:  begin
          drp_thr_q <= pwdata[6:0];
          drp_err_q <= pwdata[31:16];
        end
        bsm_pkg::OFS_TIMES: begin
          add_time_q <= pwdata[15:0];
          drp_time_q <= pwdata[31:16];
        end
        bsm_pkg::OFS_ROT:   rot_time_q <= pwdata[15:0];
        bsm_pkg::OFS_GROUP: group_q <= pwdata[15:0];
        bsm_pkg::OFS_GAIN:  kp_q <= pwdata[7:0];
        default:            ;
      endcase
    end
  end

  // thermostat pin crosses in through three flops; accepted when the last two agree
  always_ff @(posedge clock) begin
    if (rst) begin
      stat_s1_q <= 1'b0;
      stat_s2_q <= 1'b0;
      stat_s3_q <= 1'b0;
      stat_q    <= 1'b0;
    end else begin
      stat_s1_q <= stat_pin;
      stat_s2_q <= stat_s1_q;
      stat_s3_q <= stat_s2_q;
      if (stat_s2_q == stat_s3_q) begin
        stat_q <= stat_s3_q;
      end
    end
  end

  assign call = ctrl_q[bsm_pkg::CTRL_EN]
              & (ctrl_q[bsm_pkg::CTRL_REMOTE] ? remote_stat : stat_q);

  // follower view, stage choice and lead rotation candidate
  always_comb begin
    avail     = '0;
    nfire     = 4'h0;
    navail    = 4'h0;
    add_idx   = 3'h0;
    have_add  = 1'b0;
    drp_idx   = 3'h0;
    have_drp  = 1'b0;
    next_lead = lead_q;
    rl_short  = 1'b0;
    rl_excess = 1'b0;
    out_sum   = 19'h0;
    for (int i = 0; i < NF; i++) begin
      avail[i] = flw_stat[i].avail;
    end
    live = fire_q & avail;
    for (int i = 0; i < NF; i++) begin
      if (avail[i]) begin
        navail = navail + 4'h1;
      end
      if (live[i]) begin
        nfire   = nfire + 4'h1;
        out_sum = out_sum + {3'h0, flw_stat[i].outlet};
        if (flw_stat[i].runlim && flw_stat[i].actual < cmd_q[i].rate) begin
          rl_short = 1'b1;
        end
        if (flw_stat[i].runlim && flw_stat[i].actual > cmd_q[i].rate) begin
          rl_excess = 1'b1;
        end
        if (!have_drp || rank(3'(i), lead_q, group_q[2*i+:2]) >
                         rank(drp_idx, lead_q, group_q[2*drp_idx+:2])) begin
          drp_idx  = 3'(i);
          have_drp = 1'b1;
        end
      end else if (avail[i]) begin
        if (!have_add || rank(3'(i), lead_q, group_q[2*i+:2]) <
                         rank(add_idx, lead_q, group_q[2*add_idx+:2])) begin
          add_idx  = 3'(i);
          have_add = 1'b1;
        end
      end
    end
    for (int k = NF - 1; k >= 1; k--) begin
      if (avail[3'(lead_q + 3'(k))] &&
          group_q[2*(3'(lead_q + 3'(k)))+:2] == bsm_pkg::GRP_EQUAL) begin
        next_lead = 3'(lead_q + 3'(k));
      end
    end
  end

  // operating point with header backup
  always_comb begin
    op_d    = hdr_temp;
    op_ok_d = 1'b1;
    if (hdr_fault) begin
      case (ctrl_q[bsm_pkg::CTRL_BK_LO+:2])
        bsm_pkg::BK_LEAD: op_d = flw_stat[lead_q].outlet;
        bsm_pkg::BK_AVG:  op_d = (nfire == 4'h0) ? flw_stat[lead_q].outlet
                                 : 16'(out_sum / {15'h0, nfire});
        default:          op_ok_d = 1'b0;
      endcase
    end
  end

  always_ff @(posedge clock) begin
    if (rst) begin
      op_q    <= 16'h0;
      op_ok_q <= 1'b0;
    end else begin
      op_q    <= op_d;
      op_ok_q <= op_ok_d;
    end
  end

  assign err      = $signed({2'h0, setp_q}) - $signed({2'h0, op_q});
  assign add_crit = (pid_q >= add_thr_q || rl_short) && have_add
                  && err >= $signed({2'h0, add_err_q});
  assign drp_crit = (pid_q <= drp_thr_q || rl_excess) && nfire > 4'h1
                  && -err >= $signed({2'h0, drp_err_q});

  // one-second tick for detection, rotation and loop timing
  always_ff @(posedge clock) begin
    if (rst) begin
      pre_q  <= 32'h0;
      tick_q <= 1'b0;
    end else begin
      tick_q <= (pre_q == 32'(TICK_CYCLES - 1));
      pre_q  <= (pre_q == 32'(TICK_CYCLES - 1)) ? 32'h0 : pre_q + 32'h1;
    end
  end

  // loop output: P term plus an integrator stepped once a tick
  assign pterm = (28'(err) * $signed({20'h0, kp_q})) >>> 4;

  always_ff @(posedge clock) begin
    if (rst) begin
      integ_q <= 9'sh000;
      pid_q   <= 7'h00;
    end else if (!demand_q) begin
      integ_q <= 9'sh000;
      pid_q   <= 7'h00;
    end else begin
      if (tick_q) begin
        if (err > 0 && integ_q < 9'sd100) begin
          integ_q <= integ_q + 9'sd1;
        end else if (err < 0 && integ_q > 9'sd0) begin
          integ_q <= integ_q - 9'sd1;
        end
      end
      pid_q <= clamp_rate(pterm + 28'(integ_q));
    end
  end

  // heat cycle on/off with hysteresis; rotation only at the cycle start
  always_ff @(posedge clock) begin
    if (rst) begin
      demand_q   <= 1'b0;
      lead_q     <= 3'h0;
      rot_pend_q <= 1'b0;
      rot_cnt_q  <= 16'h0;
      lead_addr_q <= bsm_pkg::COORD_ADDR;
    end else begin
      lead_addr_q <= {1'b0, lead_q} + bsm_pkg::COORD_ADDR;
      if (!demand_q) begin
        if (call && op_ok_q && err >= $signed({10'h0, hon_q})) begin
          demand_q <= 1'b1;
          if (rot_pend_q) begin
            lead_q     <= next_lead;
            rot_pend_q <= 1'b0;
          end
        end
      end else if (!call || !op_ok_q || -err >= $signed({10'h0, hoff_q})) begin
        demand_q <= 1'b0;
      end
      if (demand_q && tick_q && !rot_pend_q) begin
        if (rot_cnt_q + 16'h1 >= rot_time_q) begin
          rot_pend_q <= 1'b1;
          rot_cnt_q  <= 16'h0;
        end else begin
          rot_cnt_q <= rot_cnt_q + 16'h1;
        end
      end
    end
  end

  // staging machine: four states, timers restart on any criterion loss
  always_ff @(posedge clock) begin
    if (rst) begin
      state_q   <= bsm_pkg::ST_OFF;
      fire_q    <= 8'h00;
      add_cnt_q <= 16'h0;
      drp_cnt_q <= 16'h0;
    end else if (!demand_q) begin
      state_q   <= bsm_pkg::ST_OFF;
      fire_q    <= 8'h00;
      add_cnt_q <= 16'h0;
      drp_cnt_q <= 16'h0;
    end else begin
      fire_q <= live;
      case (state_q)
        bsm_pkg::ST_OFF: begin
          state_q <= bsm_pkg::ST_WATCH;
        end
        bsm_pkg::ST_WATCH: begin
          add_cnt_q <= 16'h0;
          drp_cnt_q <= 16'h0;
          if (nfire == 4'h0 && have_add) begin
            fire_q[add_idx] <= 1'b1;
          end else if (add_crit) begin
            state_q <= bsm_pkg::ST_ADD;
          end else if (drp_crit) begin
            state_q <= bsm_pkg::ST_DROP;
          end
        end
        bsm_pkg::ST_ADD: begin
          if (!add_crit) begin
            add_cnt_q <= 16'h0;
            state_q   <= bsm_pkg::ST_WATCH;
          end else if (add_cnt_q >= add_time_q) begin
            fire_q[add_idx] <= 1'b1;
            state_q         <= bsm_pkg::ST_WATCH;
          end else if (tick_q) begin
            add_cnt_q <= add_cnt_q + 16'h1;
          end
        end
        bsm_pkg::ST_DROP: begin
          if (!drp_crit) begin
            drp_cnt_q <= 16'h0;
            state_q   <= bsm_pkg::ST_WATCH;
          end else if (drp_cnt_q >= drp_time_q) begin
            fire_q[drp_idx] <= 1'b0;
            state_q         <= bsm_pkg::ST_WATCH;
          end else if (tick_q) begin
            drp_cnt_q <= drp_cnt_q + 16'h1;
          end
        end
        default: state_q <= bsm_pkg::ST_OFF;
      endcase
    end
  end

  // rate allocation under the common base-load cap
  assign all_fire = (nfire == navail);
  assign limit    = all_fire ? bsm_pkg::RATE_FULL : base_q;
  assign share    = (nfire == 4'h0) ? 7'h00
                  : clamp_rate(28'(({4'h0, pid_q} * {7'h0, navail}) / {7'h0, nfire}));

  // sub-minimum rates pass through untouched; each follower clamps to its own minimum
  always_ff @(posedge clock) begin
    if (rst) begin
      cmd_q <= '0;
    end else begin
      for (int i = 0; i < NF; i++) begin
        cmd_q[i].fire <= fire_q[i] & avail[i];
        if (!(fire_q[i] & avail[i])) begin
          cmd_q[i].rate <= 7'h00;
        end else if (ctrl_q[bsm_pkg::CTRL_PROP] && flw_stat[i].runlim) begin
          cmd_q[i].rate <= flw_stat[i].actual;
        end else if (ctrl_q[bsm_pkg::CTRL_PROP]) begin
          cmd_q[i].rate <= (share > limit) ? limit : share;
        end else begin
          cmd_q[i].rate <= (pid_q > limit) ? limit : pid_q;
        end
      end
    end
  end

  assign prdata      = prdata_q;
  assign pready      = pready_q;
  assign pslverr     = pslverr_q;
  assign flw_cmd     = cmd_q;
  assign heat_demand = demand_q;
  assign lead_addr   = lead_addr_q;
endmodule : bsm_top

// >>> tb/bsm_sva.sv
// Purpose: port checker for the staging coordinator
// Assumes: single clock, rst synchronous active high
// Notes: lockout check allows the two-stage fire pipeline to settle
`timescale 1ns/1ps
module bsm_sva #(
  parameter int TICK_CYCLES = 10
) (
  input wire logic                                  clock,
  input wire logic                                  rst,
  input wire logic [7:0]                            paddr,
  input wire logic                                  psel,
  input wire logic                                  penable,
  input wire logic                                  pwrite,
  input wire logic [31:0]                           pwdata,
  input wire logic [31:0]                           prdata,
  input wire logic                                  pready,
  input wire logic                                  pslverr,
  input wire logic                                  stat_pin,
  input wire logic                                  remote_stat,
  input wire logic [15:0]                           hdr_temp,
  input wire logic                                  hdr_fault,
  input wire bsm_pkg::bsm_flw_t [bsm_pkg::NFLW-1:0] flw_stat,
  input wire bsm_pkg::bsm_cmd_t [bsm_pkg::NFLW-1:0] flw_cmd,
  input wire logic                                  heat_demand,
  input wire logic [3:0]                            lead_addr
);
  logic [7:0] fire_v, avail_v, over_v, avail_q, avail_q2;
  always_comb begin
    for (int i = 0; i < bsm_pkg::NFLW; i++) begin
      fire_v[i]  = flw_cmd[i].fire;
      avail_v[i] = flw_stat[i].avail;
      over_v[i]  = flw_cmd[i].rate > bsm_pkg::RATE_FULL;
    end
  end
  always_ff @(posedge clock) begin
    avail_q  <= avail_v;
    avail_q2 <= avail_q;
  end
  default clocking @(posedge clock); endclocking
  default disable iff (rst);
  a_apb_one_wait: assert property (psel && penable && !pready |=> pready)
    else $error("no answer one cycle after apb access");
  a_ready_pulse: assert property (pready |=> !pready) else $error("pready held too long");
  a_err_cause: assert property (pslverr |-> pready && $past(psel && penable))
    else $error("pslverr without an access");
  a_rate_full: assert property (over_v == 8'h00) else $error("rate above full scale");
  a_lockout_skip: assert property ((fire_v & ~avail_v & ~avail_q & ~avail_q2) == 8'h00)
    else $error("locked-out slot fired");
  a_idle_quiet: assert property (!heat_demand [*3] |-> fire_v == 8'h00)
    else $error("fire without demand");
  a_fire_demand: assert property ($rose(|fire_v) |-> heat_demand)
    else $error("first stage without demand");
  a_lead_range: assert property (lead_addr >= 4'h1 && lead_addr <= 4'h8)
    else $error("lead address out of range");
  a_lead_change: assert property ($changed(lead_addr) |-> heat_demand)
    else $error("lead moved outside heat cycle start");
endmodule : bsm_sva

bind bsm_top bsm_sva #(.TICK_CYCLES(TICK_CYCLES)) bsm_sva_inst (
  .clock(clock), .rst(rst), .paddr(paddr), .psel(psel), .penable(penable),
  .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
  .stat_pin(stat_pin), .remote_stat(remote_stat), .hdr_temp(hdr_temp),
  .hdr_fault(hdr_fault), .flw_stat(flw_stat), .flw_cmd(flw_cmd),
  .heat_demand(heat_demand), .lead_addr(lead_addr));

// >>> tb/bsm_flw_model.sv
// Purpose: behavioural followers answering the coordinator's command words
// Assumes: slot i is the follower at link address i+1
// Notes: no run-limit behaviour; lock input forces lockout per slot
`timescale 1ns/1ps
module bsm_flw_model #(
  parameter logic [6:0]  MIN_RATE = 7'h14,
  parameter logic [15:0] OUT_TEMP = 16'h03E8
) (
  input  wire logic                                  clock,
  input  wire logic [7:0]                            lock,
  input  wire bsm_pkg::bsm_cmd_t [bsm_pkg::NFLW-1:0] flw_cmd,
  output bsm_pkg::bsm_flw_t [bsm_pkg::NFLW-1:0]      flw_stat
);
  initial flw_stat = '0;
  // status answers only through the status word, one slot per address
  always @(posedge clock) begin
    for (int i = 0; i < bsm_pkg::NFLW; i++) begin
      flw_stat[i].avail  <= ~lock[i];
      flw_stat[i].runlim <= 1'b0;
      // a low command still fires at the minimum rate
      flw_stat[i].actual <= !flw_cmd[i].fire ? 7'h00 :
                            (flw_cmd[i].rate < MIN_RATE ? MIN_RATE : flw_cmd[i].rate);
      flw_stat[i].outlet <= flw_cmd[i].fire ? OUT_TEMP + 16'h0010 : OUT_TEMP;
    end
  end
endmodule : bsm_flw_model

// >>> tb/testbench.sv
// Purpose: self-checking bench for the staging coordinator
// Assumes: tick shortened to 10 cycles
// Notes: apb answers are queued by the driver and compared by a monitor
`timescale 1ns/1ps
module testbench;
  logic                                  clock, rst, psel, penable, pwrite, pready, pslverr;
  logic                                  stat_pin, remote_stat, hdr_fault, heat_demand;
  logic [7:0]                            paddr, lock, fire_v;
  logic [31:0]                           pwdata, prdata;
  logic [15:0]                           hdr_temp;
  logic [3:0]                            lead_addr;
  bsm_pkg::bsm_flw_t [bsm_pkg::NFLW-1:0] flw_stat;
  bsm_pkg::bsm_cmd_t [bsm_pkg::NFLW-1:0] flw_cmd;
  logic [33:0]                           expq[$];
  logic [33:0]                           e;
  logic [7:0]                            wa[8] = '{8'h04, 8'h08, 8'h0C, 8'h10, 8'h18, 8'h20,
                                                   8'h1C, 8'h00};
  logic [31:0]                           wd[8] = '{32'h03E8, 32'h0A0A, 32'h32, 32'h0005_0000,
                                                   32'h003C_0002, 32'h5515, 32'h2, 32'h5};
  int                                    errors, checks_done, n;

  bsm_top #(.TICK_CYCLES(10)) bsm_top_inst (.clock(clock), .rst(rst), .paddr(paddr),
    .psel(psel), .penable(penable), .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .stat_pin(stat_pin), .remote_stat(remote_stat),
    .hdr_temp(hdr_temp), .hdr_fault(hdr_fault), .flw_stat(flw_stat), .flw_cmd(flw_cmd),
    .heat_demand(heat_demand), .lead_addr(lead_addr));
  bsm_flw_model bsm_flw_model_inst (.clock(clock), .lock(lock), .flw_cmd(flw_cmd),
    .flw_stat(flw_stat));

  initial begin
    clock = 1'b0;
    forever #4 clock = ~clock;
  end
  always_comb begin
    for (int i = 0; i < 8; i++) fire_v[i] = flw_cmd[i].fire;
  end

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    checks_done++;
    if (seen !== exp) begin
      errors++;
      $display("mismatch %0t seen %h expected %h", $time, seen, exp);
    end
  endtask : check

  task automatic summarize();
    $display("errors %0d checks %0d", errors, checks_done);
    if (errors == 0 && checks_done > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask : summarize

  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d,
                     input logic [33:0] x);
    int k;
    expq.push_back(x);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= wr;
    paddr   <= a;
    pwdata  <= d;
    @(posedge clock);
    penable <= 1'b1;
    k = 0;
    do begin
      @(posedge clock);
      k++;
    end while (pready !== 1'b1 && k < 50);
    psel    <= 1'b0;
    penable <= 1'b0;
    // one idle edge so a following call never re-drives psel in the same step
    @(posedge clock);
    if (k >= 50) begin
      errors++;
      summarize();
    end
  endtask : apb

  // kinds: 0 demand on, 1 demand off, 2 any stage fires, 3 two stages fire
  task automatic wait_for(input int kind, output int cyc);
    logic hit;
    cyc = 0;
    hit = 1'b0;
    while (!hit && cyc < 2000) begin
      @(posedge clock);
      cyc++;
      case (kind)
        0: hit = heat_demand === 1'b1;
        1: hit = heat_demand === 1'b0;
        2: hit = (|fire_v) === 1'b1;
        default: hit = $countones(fire_v) >= 2;
      endcase
    end
    if (!hit) begin
      errors++;
      summarize();
    end
  endtask : wait_for

  always @(posedge clock) begin
    if (psel && penable && pready === 1'b1 && expq.size() > 0) begin
      e = expq.pop_front();
      check({31'h0, pslverr}, {31'h0, e[32]});
      if (e[33]) check(prdata, e[31:0]);
    end
  end
  // base-load cap while not every stage fires
  always @(posedge clock) begin
    if (heat_demand === 1'b1 && fire_v !== 8'hFF) begin
      for (int i = 0; i < 8; i++) if (flw_cmd[i].fire) check(32'(flw_cmd[i].rate > 7'h32), 0);
    end
  end

  initial begin
    {rst, psel, penable, pwrite, stat_pin, remote_stat, hdr_fault} = 7'h40;
    {paddr, pwdata, lock, errors, checks_done} = '0;
    hdr_temp = 16'h03F0;
    void'($urandom(32'h558a));
    repeat (4) @(posedge clock);
    rst <= 1'b0;
    @(posedge clock);
    apb(1'b0, bsm_pkg::OFS_CTRL, 32'h0, {2'b10, 32'h0});
    apb(1'b0, bsm_pkg::OFS_SETP, 32'h0, {2'b10, 16'h0, bsm_pkg::RST_SETP});
    apb(1'b0, bsm_pkg::OFS_BASE, 32'h0, {2'b10, 25'h0, bsm_pkg::RST_BASE});
    apb(1'b0, 8'h30, 32'h0, {2'b11, 32'h0});
    foreach (wa[i]) apb(1'b1, wa[i], wd[i], 34'h0);
    remote_stat <= 1'b1;
    repeat (20) @(posedge clock);
    check({31'h0, heat_demand}, 32'h0);
    hdr_temp <= 16'h03DE;
    wait_for(0, n);
    wait_for(2, n);
    check({24'h0, fire_v}, 32'h08);
    check({28'h0, lead_addr}, 32'h1);
    hdr_temp <= 16'h03E8 - 16'(30 + $urandom_range(20));
    wait_for(3, n);
    check(32'(n > 10), 32'h1);
    hdr_temp <= 16'h03F2;
    wait_for(1, n);
    repeat (2) @(posedge clock);
    check({24'h0, fire_v}, 32'h0);
    lock        <= 8'h08;
    remote_stat <= 1'b0;
    stat_pin    <= 1'b1;
    apb(1'b1, bsm_pkg::OFS_CTRL, 32'h1, 34'h0);
    hdr_temp <= 16'h03DE;
    wait_for(0, n);
    wait_for(2, n);
    check({24'h0, fire_v}, 32'h02);
    check({28'h0, lead_addr}, 32'h2);
    hdr_fault <= 1'b1;
    wait_for(1, n);
    check({31'h0, heat_demand}, 32'h0);
    // lead outlet backup: idle lead outlet sits at setpoint minus on-hysteresis
    apb(1'b1, bsm_pkg::OFS_SETP, 32'h03F2, 34'h0);
    apb(1'b1, bsm_pkg::OFS_CTRL, 32'h9, 34'h0);
    wait_for(0, n);
    check({31'h0, heat_demand}, 32'h1);
    summarize();
  end
endmodule : testbench
